// ==== rtl/dfc_pkg.sv ====
/*
 * Shared constants of the decimation filter configuration block: register
 * addresses, field positions, reset values, ratio tables and timing counts.
 * Assumes a single converter clock of 10 MHz with a modulator tick every
 * second clock.
 */
// What this block does
// - Stage select meaning depends on current filter mode.
// - Wideband: 000b preset, 111b programmable FIR coefficients.
// - Sinc: 000b fourth-order, 001b third-order first stage.
// - Ratio field bits 4:0, reset 00000b.
// - Codes 0-7: wideband, ratios 32 through 4096.
// - Wideband ratio halves per bypassed FIR section.
// - Output samples at modulator rate over ratio.
// - Codes 8-13: sinc ratios 12 to 128.
// - Codes 14-23: sinc ratios, mid-speed alternate table.
// - Codes 24-27: single sinc stage, long ratios.
// - Codes 28-31: sinc cascaded with first-order sinc.
// - Second byte at 0Ah, reset 01h, fixed layout.
// - Start delay codes give modulator period waits.
// - Order bit: 0 third FIR first, 1 recursive first.
// - Bypass bit 1 disables its section; recursive off.
// - Mid-speed is speed select 01b.
`default_nettype none
package dfc_pkg;
   localparam logic [7:0] DFC_ADDR_CTRL_ONE = 8'h09;
   localparam logic [7:0] DFC_ADDR_CTRL_TWO = 8'h0A;
   localparam logic [7:0] DFC_CTRL_ONE_RESET = 8'h00;
   localparam logic [7:0] DFC_CTRL_TWO_RESET = 8'h01;
   localparam logic [7:0] DFC_CTRL_TWO_WMASK = 8'h7F;
   localparam int DFC_SEL_MSB = 7;
   localparam int DFC_SEL_LSB = 5;
   localparam int DFC_RATIO_MSB = 4;
   localparam int DFC_DELAY_MSB = 6;
   localparam int DFC_DELAY_LSB = 4;
   localparam int DFC_ORDER_BIT = 3;
   localparam int DFC_FIR2_BIT = 2;
   localparam int DFC_FIR3_BIT = 1;
   localparam int DFC_REC_BIT = 0;
   localparam logic [2:0] DFC_SEL_PRESET = 3'h0;
   localparam logic [2:0] DFC_SEL_PROG = 3'h7;
   localparam logic [2:0] DFC_SEL_SINC4 = 3'h0;
   localparam logic [2:0] DFC_SEL_SINC3 = 3'h1;
   localparam logic [4:0] DFC_LAST_WIDEBAND = 5'h07;
   localparam logic [4:0] DFC_FIRST_MIDTAB = 5'h0E;
   localparam logic [4:0] DFC_FIRST_SINGLE = 5'h18;
   localparam logic [4:0] DFC_FIRST_CASCADE = 5'h1C;
   localparam logic [1:0] DFC_SPEED_MID = 2'h1;
   localparam int DFC_CLK_PER_MOD = 2;
   localparam int DFC_DATA_W = 24;
   localparam int DFC_FIFO_DEPTH = 32;
   localparam int DFC_OSR_W = 18;
   localparam int DFC_DLY_W = 12;

   // Ratio for each code in normal speed modes.
   localparam logic [17:0] DFC_OSR_NORMAL [0:31] = '{
      18'h0_0020, 18'h0_0040, 18'h0_0080, 18'h0_0100,
      18'h0_0200, 18'h0_0400, 18'h0_0800, 18'h0_1000,
      18'h0_000C, 18'h0_0010, 18'h0_0018, 18'h0_0020,
      18'h0_0040, 18'h0_0080, 18'h0_0100, 18'h0_014D,
      18'h0_0200, 18'h0_029B, 18'h0_0400, 18'h0_0535,
      18'h0_0800, 18'h0_0A6B, 18'h0_1000, 18'h0_14D5,
      18'h0_682B, 18'h0_7D00, 18'h1_7700, 18'h2_7100,
      18'h0_6820, 18'h0_7D00, 18'h1_7700, 18'h2_7100};
   // Ratio in mid-speed mode for codes from DFC_FIRST_MIDTAB upward.
   localparam logic [17:0] DFC_OSR_MID [0:17] = '{
      18'h0_00A7, 18'h0_0100, 18'h0_014D, 18'h0_0200,
      18'h0_029B, 18'h0_0400, 18'h0_0535, 18'h0_0800,
      18'h0_0A6B, 18'h0_1000,
      18'h0_3415, 18'h0_3E80, 18'h0_BB80, 18'h1_3880,
      18'h0_3416, 18'h0_3E80, 18'h0_BB80, 18'h1_3880};
   // Start delay per code, in modulator periods.
   localparam logic [10:0] DFC_DELAY_MOD [0:7] = '{
      11'h000, 11'h004, 11'h008, 11'h010, 11'h020, 11'h080, 11'h200, 11'h400};

   typedef enum logic [1:0] {
      DFC_IDLE  = 2'b00,
      DFC_DELAY = 2'b01,
      DFC_RUN   = 2'b10
   } dfc_state_t;
endpackage
`default_nettype wire

// ==== rtl/dfc_stream_if.sv ====
/*
 * Valid/ready word stream between the block and its sample FIFO.
 * Assumes both ends share one clock.
 */
`default_nettype none
interface dfc_stream_if #(parameter int WIDTH = 24);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== rtl/dfc_fifo.sv ====
/*
 * Sample FIFO with parameter width and depth; the read word comes from a
 * register. Assumes one clock and an asynchronous active-low reset.
 */
`default_nettype none
module dfc_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
) (
   input wire logic   clock,
   input wire logic   resetn,
   dfc_stream_if.sink wr,
   dfc_stream_if.source rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0]    wptr_reg, wptr_next, rptr_reg, rptr_next;
   logic [AW:0]      count_reg, count_next;
   logic             oval_reg, oval_next;
   logic [WIDTH-1:0] odata_reg;
   logic             push, pop, load;

   // ==========================================================
   // Control
   assign wr.ready = (count_reg != (AW+1)'(DEPTH));
   assign push = wr.valid && wr.ready;
   assign load = (count_reg != '0) && (!oval_reg || rd.ready);
   assign pop  = load;
   assign rd.valid = oval_reg;
   assign rd.data  = odata_reg;

   always_comb begin
      wptr_next  = push ? wptr_reg + AW'(1) : wptr_reg;
      rptr_next  = pop ? rptr_reg + AW'(1) : rptr_reg;
      count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
      if (load) begin
         oval_next = 1'b1;
      end else if (rd.ready) begin
         oval_next = 1'b0;
      end else begin
         oval_next = oval_reg;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wptr_reg  <= '0;
         rptr_reg  <= '0;
         count_reg <= '0;
         oval_reg  <= 1'b0;
      end else begin
         wptr_reg  <= wptr_next;
         rptr_reg  <= rptr_next;
         count_reg <= count_next;
         oval_reg  <= oval_next;
      end
   end

   // ==========================================================
   // Storage
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wptr_reg] <= wr.data;
      end
      if (load) begin
         odata_reg <= mem[rptr_reg];
      end
   end
endmodule
`default_nettype wire

// ==== rtl/dfc_top.sv ====
/*
 * Decimation filter configuration: the two filter control bytes, their
 * decode into mode, coefficient, stage and ratio selections, the start
 * delay, the output sample pacing and the sample FIFO.
 * Assumes the serial front end presents one-cycle register strobes and
 * the filter arithmetic presents its current result word.
 */
`default_nettype none
module dfc_top
   import dfc_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  resetn,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_write,
   output logic      [7:0]            reg_rdata,
   input  wire logic [1:0]            speed_mode_select,
   input  wire logic                  start_request,
   input  wire logic                  stop_request,
   input  wire logic [DFC_DATA_W-1:0] filter_result,
   output logic                       sinc_mode,
   output logic                       fir_coeff_programmable,
   output logic                       sinc_third_order,
   output logic                       sinc_first_order_cascade,
   output logic                       section_order_select,
   output logic                       second_fir_bypass,
   output logic                       third_fir_bypass,
   output logic                       recursive_section_bypass,
   output logic      [DFC_OSR_W-1:0]  effective_ratio,
   output logic                       conversion_active,
   output logic                       modulator_tick,
   output logic                       sample_tick,
   output logic                       sample_overrun,
   output logic      [DFC_DATA_W-1:0] sample_data,
   output logic                       sample_valid,
   input  wire logic                  sample_ready
);
   logic [7:0]           ctrl_one_reg, ctrl_one_next;
   logic [7:0]           ctrl_two_reg, ctrl_two_next;
   logic [7:0]           rdata_reg, rdata_next;
   logic [2:0]           stage_sel;
   logic [4:0]           ratio_sel;
   logic [2:0]           delay_sel;
   logic                 mid_speed;
   logic                 sinc_mode_next;
   logic                 fir_prog_next;
   logic                 sinc3_next;
   logic                 cascade_next;
   logic [DFC_OSR_W-1:0] base_ratio;
   logic [DFC_OSR_W-1:0] ratio_next;
   logic [5:0]           flags_reg, flags_next;
   logic [DFC_OSR_W-1:0] ratio_reg;
   dfc_state_t           state_reg, state_next;
   logic [DFC_DLY_W-1:0] dly_reg, dly_next;
   logic                 phase_reg, phase_next;
   logic [DFC_OSR_W-1:0] osr_cnt_reg, osr_cnt_next;
   logic                 overrun_reg, overrun_next;
   logic                 fire;

   dfc_stream_if #(.WIDTH(DFC_DATA_W)) push_if ();
   dfc_stream_if #(.WIDTH(DFC_DATA_W)) drain_if ();

   // ==========================================================
   // Register file
   always_comb begin
      ctrl_one_next = ctrl_one_reg;
      ctrl_two_next = ctrl_two_reg;
      if (reg_write && reg_addr == DFC_ADDR_CTRL_ONE) begin
         ctrl_one_next = reg_wdata;
      end
      if (reg_write && reg_addr == DFC_ADDR_CTRL_TWO) begin
         ctrl_two_next = reg_wdata & DFC_CTRL_TWO_WMASK;
      end
      case (reg_addr)
         DFC_ADDR_CTRL_ONE: rdata_next = ctrl_one_reg;
         DFC_ADDR_CTRL_TWO: rdata_next = ctrl_two_reg;
         default:           rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctrl_one_reg <= DFC_CTRL_ONE_RESET;
         ctrl_two_reg <= DFC_CTRL_TWO_RESET;
         rdata_reg    <= 8'h00;
      end else begin
         ctrl_one_reg <= ctrl_one_next;
         ctrl_two_reg <= ctrl_two_next;
         rdata_reg    <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // ==========================================================
   // Mode and ratio decode
   assign stage_sel = ctrl_one_reg[DFC_SEL_MSB:DFC_SEL_LSB];
   assign ratio_sel = ctrl_one_reg[DFC_RATIO_MSB:0];
   assign delay_sel = ctrl_two_reg[DFC_DELAY_MSB:DFC_DELAY_LSB];
   assign mid_speed = (speed_mode_select == DFC_SPEED_MID);

   always_comb begin
      sinc_mode_next = (ratio_sel > DFC_LAST_WIDEBAND);
      // Reserved stage codes fall back to the preset set or to sinc4.
      fir_prog_next  = !sinc_mode_next && (stage_sel == DFC_SEL_PROG);
      sinc3_next     = sinc_mode_next && (stage_sel == DFC_SEL_SINC3);
      cascade_next   = (ratio_sel >= DFC_FIRST_CASCADE);
      if (mid_speed && ratio_sel >= DFC_FIRST_MIDTAB) begin
         base_ratio = DFC_OSR_MID[ratio_sel - DFC_FIRST_MIDTAB];
      end else begin
         base_ratio = DFC_OSR_NORMAL[ratio_sel];
      end
      ratio_next = base_ratio;
      if (!sinc_mode_next) begin
         case ({ctrl_two_reg[DFC_FIR2_BIT], ctrl_two_reg[DFC_FIR3_BIT]})
            2'b00:   ratio_next = base_ratio;
            2'b11:   ratio_next = base_ratio >> 2;
            default: ratio_next = base_ratio >> 1;
         endcase
      end
      flags_next = {sinc_mode_next, fir_prog_next, sinc3_next, cascade_next,
                    ctrl_two_reg[DFC_ORDER_BIT], ctrl_two_reg[DFC_REC_BIT]};
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         flags_reg <= 6'h01;
         ratio_reg <= DFC_OSR_NORMAL[0];
      end else begin
         flags_reg <= flags_next;
         ratio_reg <= ratio_next;
      end
   end

   assign sinc_mode                = flags_reg[5];
   assign fir_coeff_programmable   = flags_reg[4];
   assign sinc_third_order         = flags_reg[3];
   assign sinc_first_order_cascade = flags_reg[2];
   assign section_order_select     = flags_reg[1];
   assign recursive_section_bypass = flags_reg[0];
   assign second_fir_bypass        = ctrl_two_reg[DFC_FIR2_BIT];
   assign third_fir_bypass         = ctrl_two_reg[DFC_FIR3_BIT];
   assign effective_ratio          = ratio_reg;

   // ==========================================================
   // Start delay and sample pacing
   // Samples are taken only while the FIFO can accept them; a full FIFO
   // holds the counter at its last count and flags an overrun.
   assign fire = (state_reg == DFC_RUN) && phase_reg
                 && (osr_cnt_reg >= ratio_reg - DFC_OSR_W'(1));

   always_comb begin
      state_next   = state_reg;
      dly_next     = dly_reg;
      phase_next   = !phase_reg;
      osr_cnt_next = osr_cnt_reg;
      overrun_next = overrun_reg && !start_request;
      case (state_reg)
         DFC_IDLE: begin
            phase_next = 1'b0;
            if (start_request) begin
               osr_cnt_next = '0;
               dly_next = DFC_DLY_W'(DFC_DELAY_MOD[delay_sel]) * DFC_DLY_W'(DFC_CLK_PER_MOD);
               state_next = (delay_sel == 3'h0) ? DFC_RUN : DFC_DELAY;
            end
         end
         DFC_DELAY: begin
            phase_next = 1'b0;
            if (dly_reg <= DFC_DLY_W'(1)) begin
               state_next = DFC_RUN;
            end else begin
               dly_next = dly_reg - DFC_DLY_W'(1);
            end
         end
         DFC_RUN: begin
            if (phase_reg) begin
               if (fire) begin
                  if (push_if.ready) begin
                     osr_cnt_next = '0;
                  end else begin
                     overrun_next = 1'b1;
                  end
               end else begin
                  osr_cnt_next = osr_cnt_reg + DFC_OSR_W'(1);
               end
            end
         end
         default: state_next = DFC_IDLE;
      endcase
      if (stop_request) begin
         state_next = DFC_IDLE;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg   <= DFC_IDLE;
         dly_reg     <= '0;
         phase_reg   <= 1'b0;
         osr_cnt_reg <= '0;
         overrun_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         dly_reg     <= dly_next;
         phase_reg   <= phase_next;
         osr_cnt_reg <= osr_cnt_next;
         overrun_reg <= overrun_next;
      end
   end

   assign conversion_active = (state_reg == DFC_RUN);
   assign modulator_tick    = conversion_active && phase_reg;
   assign sample_tick       = fire && push_if.ready;
   assign sample_overrun    = overrun_reg;

   // ==========================================================
   // Sample FIFO
   assign push_if.valid  = sample_tick;
   assign push_if.data   = filter_result;
   assign drain_if.ready = sample_ready;
   assign sample_valid   = drain_if.valid;
   assign sample_data    = drain_if.data;

   dfc_fifo #(
      .WIDTH(DFC_DATA_W),
      .DEPTH(DFC_FIFO_DEPTH)
   ) u_fifo (
      .clock (clock),
      .resetn(resetn),
      .wr    (push_if.sink),
      .rd    (drain_if.source)
   );
endmodule
`default_nettype wire

// ==== verification/dfc_props.sv ====
/*
 * Port assertions of the decimation filter configuration block.
 * Assumes it is bound to dfc_top and sees only that module's ports.
 */
`default_nettype none
module dfc_props
   import dfc_pkg::*;
(
   input wire logic                  clock,
   input wire logic                  resetn,
   input wire logic [7:0]            reg_addr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_write,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  sinc_mode,
   input wire logic                  fir_coeff_programmable,
   input wire logic                  sinc_third_order,
   input wire logic                  sinc_first_order_cascade,
   input wire logic                  section_order_select,
   input wire logic                  second_fir_bypass,
   input wire logic                  third_fir_bypass,
   input wire logic                  recursive_section_bypass,
   input wire logic                  modulator_tick,
   input wire logic                  sample_tick,
   input wire logic [DFC_DATA_W-1:0] sample_data,
   input wire logic                  sample_valid,
   input wire logic                  sample_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Shadow copies of both control bytes
   logic [7:0] one_reg, one_next, two_reg, two_next;
   logic       sinc_w;
   assign sinc_w = one_reg[4:0] > DFC_LAST_WIDEBAND;
   always_comb begin
      one_next = one_reg;
      two_next = two_reg;
      if (reg_write && reg_addr == DFC_ADDR_CTRL_ONE)
         one_next = reg_wdata;
      if (reg_write && reg_addr == DFC_ADDR_CTRL_TWO)
         two_next = reg_wdata & DFC_CTRL_TWO_WMASK;
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         one_reg <= DFC_CTRL_ONE_RESET;
         two_reg <= DFC_CTRL_TWO_RESET;
      end else begin
         one_reg <= one_next;
         two_reg <= two_next;
      end
   end
   // ==========================================================
   // Assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   chk_mode_decode: assert property (sinc_mode == $past(sinc_w))
      else $error("filter mode does not follow the ratio code");
   chk_prog_coeff: assert property (fir_coeff_programmable ==
      $past(!sinc_w && one_reg[7:5] == DFC_SEL_PROG))
      else $error("coefficient choice wrong");
   chk_third_order: assert property (sinc_third_order ==
      $past(sinc_w && one_reg[7:5] == DFC_SEL_SINC3))
      else $error("sinc order choice wrong");
   chk_cascade_stage: assert property (sinc_first_order_cascade ==
      $past(one_reg[4:0] >= DFC_FIRST_CASCADE))
      else $error("cascade flag wrong");
   chk_fir_bypass: assert property (second_fir_bypass == two_reg[2] &&
      third_fir_bypass == two_reg[1])
      else $error("fir bypass bits wrong");
   chk_rec_bypass: assert property (recursive_section_bypass == $past(two_reg[0]))
      else $error("recursive bypass wrong");
   chk_order_bit: assert property (section_order_select == $past(two_reg[3]))
      else $error("section order wrong");
   chk_read_back: assert property ($past(resetn) && !$past(reg_write) &&
      $past(reg_addr) == DFC_ADDR_CTRL_TWO |-> reg_rdata == $past(two_reg))
      else $error("second byte read back wrong");
   chk_mod_rate: assert property (modulator_tick |=> !modulator_tick)
      else $error("modulator tick faster than half clock");
   chk_valid_hold: assert property (sample_valid && !sample_ready |=>
      sample_valid && $stable(sample_data))
      else $error("sample dropped while stalled");
   cover property (sample_tick);
   cover property (sample_valid && !sample_ready);
   cover property (reg_write && reg_addr == DFC_ADDR_CTRL_TWO);
endmodule
bind dfc_top dfc_props props (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write,
   .reg_rdata, .sinc_mode, .fir_coeff_programmable, .sinc_third_order,
   .sinc_first_order_cascade, .section_order_select, .second_fir_bypass,
   .third_fir_bypass, .recursive_section_bypass, .modulator_tick, .sample_tick,
   .sample_data, .sample_valid, .sample_ready);
`default_nettype wire

// ==== verification/dfc_host_model.sv ====
/*
 * Host that writes and addresses the filter control bytes.
 * Assumes one-cycle write strobes on the block's clock.
 */
`default_nettype none
module dfc_host_model (
   input  wire logic       clock,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_write
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
   end
   // Callers hand over documented stage codes only.
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      reg_wdata <= ~d;
   endtask
   task automatic look(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      @(posedge clock);
   endtask
endmodule
`default_nettype wire

// ==== verification/decimation_filter_config_test.sv ====
/*
 * Self-checking bench of the decimation filter configuration block.
 * Assumes the design, the checker and the host model are compiled first.
 */
`default_nettype none
module decimation_filter_config_test
   import dfc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0]  one;
      logic [7:0]  two;
      logic [1:0]  spd;
      logic [17:0] ratio;
      logic [3:0]  flags;
   } dfc_row_t;
   logic        clock = 1'b0;
   logic        resetn, reg_write, start_request, stop_request, sample_ready;
   logic        sinc_mode, fir_coeff_programmable, sinc_third_order;
   logic        sinc_first_order_cascade, section_order_select, second_fir_bypass;
   logic        third_fir_bypass, recursive_section_bypass, conversion_active;
   logic        sample_tick, sample_overrun, sample_valid;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [1:0]  speed_mode_select;
   logic [23:0] filter_result, sample_data, first_word;
   logic [17:0] effective_ratio;
   int          miscompares, checked, n, base;
   dfc_row_t    r;
   logic [10:0] dly [8] = '{11'h000, 11'h004, 11'h008, 11'h010, 11'h020, 11'h080,
                            11'h200, 11'h400};
   dfc_row_t    rows [14] = '{
      '{8'h00, 8'h01, 2'h2, 18'h0_0020, 4'h0}, '{8'hE7, 8'h01, 2'h2, 18'h0_1000, 4'h4},
      '{8'h03, 8'h05, 2'h2, 18'h0_0080, 4'h0}, '{8'h03, 8'h06, 2'h2, 18'h0_0040, 4'h0},
      '{8'h28, 8'h06, 2'h2, 18'h0_000C, 4'hA}, '{8'h0D, 8'h01, 2'h1, 18'h0_0080, 4'h8},
      '{8'h0E, 8'h01, 2'h2, 18'h0_0100, 4'h8}, '{8'h0E, 8'h01, 2'h1, 18'h0_00A7, 4'h8},
      '{8'h17, 8'h01, 2'h1, 18'h0_1000, 4'h8}, '{8'h17, 8'h01, 2'h0, 18'h0_14D5, 4'h8},
      '{8'h18, 8'h01, 2'h1, 18'h0_3415, 4'h8}, '{8'h1B, 8'h01, 2'h2, 18'h2_7100, 4'h8},
      '{8'h1C, 8'h01, 2'h1, 18'h0_3416, 4'h9}, '{8'h1F, 8'h01, 2'h3, 18'h2_7100, 4'h9}};

   dfc_top DUT (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_rdata,
      .speed_mode_select, .start_request, .stop_request, .filter_result, .sinc_mode,
      .fir_coeff_programmable, .sinc_third_order, .sinc_first_order_cascade,
      .section_order_select, .second_fir_bypass, .third_fir_bypass,
      .recursive_section_bypass, .effective_ratio, .conversion_active,
      .modulator_tick(), .sample_tick, .sample_overrun, .sample_data,
      .sample_valid, .sample_ready);
   dfc_host_model host (.clock, .reg_addr, .reg_wdata, .reg_write);

   always #50 clock = ~clock;
   always @(posedge clock) filter_result <= resetn ? filter_result + 24'h00_0001 : 24'h00_0000;

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("compares %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      host.look(a);
      @(negedge clock);
      check(reg_rdata, exp);
   endtask
   task automatic pulse(input logic go);
      @(posedge clock);
      if (go)
         start_request <= 1'b1;
      else
         stop_request <= 1'b1;
      @(posedge clock);
      start_request <= 1'b0;
      stop_request <= 1'b0;
   endtask
   task automatic waitc(input int sel, output int cnt);
      logic hit;
      cnt = 0;
      hit = 1'b0;
      while (hit !== 1'b1 && cnt < 4000) begin
         @(negedge clock);
         cnt++;
         case (sel)
            0: hit = conversion_active;
            1: hit = sample_tick;
            2: hit = sample_overrun;
            default: hit = !sample_valid;
         endcase
      end
      if (hit !== 1'b1) begin
         miscompares++;
         results();
      end
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      resetn = 1'b0;
      speed_mode_select = 2'h2;
      start_request = 1'b0;
      stop_request = 1'b0;
      sample_ready = 1'b1;
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      for (int i = 0; i < 14; i++) begin
         r = rows[i];
         host.put(DFC_ADDR_CTRL_ONE, r.one);
         speed_mode_select <= r.spd;
         host.put(DFC_ADDR_CTRL_TWO, r.two);
         repeat (3) @(negedge clock);
         check(effective_ratio, r.ratio);
         check({sinc_mode, fir_coeff_programmable, sinc_third_order,
                sinc_first_order_cascade}, r.flags);
         rd(DFC_ADDR_CTRL_ONE, r.one);
      end
      $display("ratio table done");
      @(posedge clock);
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      @(negedge clock);
      check(effective_ratio, 18'h0_0020);
      check(recursive_section_bypass, 1'b1);
      rd(DFC_ADDR_CTRL_TWO, 8'h01);
      rd(DFC_ADDR_CTRL_ONE, 8'h00);
      host.put(DFC_ADDR_CTRL_TWO, 8'hFF);
      rd(DFC_ADDR_CTRL_TWO, 8'h7F);
      check({section_order_select, second_fir_bypass, third_fir_bypass}, 3'h7);
      rd(8'h0B, 8'h00);
      $display("reset and map done");
      host.put(DFC_ADDR_CTRL_ONE, 8'h08);
      speed_mode_select <= 2'h2;
      for (int d = 0; d < 8; d++) begin
         host.put(DFC_ADDR_CTRL_TWO, {1'b0, 3'(d), 4'h1});
         pulse(1'b0);
         pulse(1'b1);
         waitc(0, n);
         if (d == 0)
            base = n;
         check(n - base, {dly[d], 1'b0});
      end
      waitc(1, n);
      waitc(1, n);
      check(n, 24'h00_0018);
      $display("start delay and pacing done");
      @(posedge clock);
      sample_ready <= 1'b0;
      waitc(2, n);
      check(sample_overrun, 1'b1);
      pulse(1'b0);
      pulse(1'b1);
      @(negedge clock);
      check(sample_overrun, 1'b0);
      pulse(1'b0);
      @(negedge clock);
      first_word = sample_data;
      @(posedge clock);
      sample_ready <= 1'b1;
      repeat (2) @(negedge clock);
      check(sample_data, first_word + 24'h00_0018);
      waitc(3, n);
      check(sample_valid, 1'b0);
      $display("fifo fill and drain done");
      results();
   end
endmodule
`default_nettype wire
